// >>> hw/quad_prescaled_timer_unit.sv
`default_nettype none
module quad_prescaled_timer_unit
  import qtimer_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,

  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,

  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,

  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,

  // timer pins
  input  wire logic        timer_clock_in_one,
  input  wire logic        timer_a_aux_input,
  input  wire logic        timer_b_aux_input,
  input  wire logic        port_line_four,
  input  wire logic        port_line_three,
  output logic             timer_a_toggle_out,
  output logic             timer_b_toggle_out,
  output logic             timer_c_toggle_out,
  output logic             timer_d_toggle_out,

  // interrupt channel requests
  output logic [3:0]       timeout_irq,
  output logic [1:0]       port_irq
);

  // ========================================
  // registers
  logic [7:0] ctrl_ab_q;
  logic [7:0] ctrl_cd_q;
  logic [7:0] edge_select_register;
  logic [5:0] irq_en_q;

  // ========================================
  // timer clock edge
  // the timer clock is sampled as a level; one tick per rising edge
  // limitation: a timer clock at or above half of ref_clk loses ticks
  logic tclk_q;
  logic tclk_prev_q;

  wire logic tick = tclk_q & ~tclk_prev_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tclk_q      <= 1'b0;
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_q      <= timer_clock_in_one;
      tclk_prev_q <= tclk_q;
    end
  end

  // ========================================
  // mode decode
  tcfg_t cfg [4];

  assign cfg[0] = decode_ab(ctrl_ab_q[CTRL_A_LSB +: 4]);
  assign cfg[1] = decode_ab(ctrl_ab_q[CTRL_B_LSB +: 4]);
  assign cfg[2] = decode_cd(ctrl_cd_q[CTRL_C_LSB +: 3]);
  assign cfg[3] = decode_cd(ctrl_cd_q[CTRL_D_LSB +: 3]);

  // ========================================
  // auxiliary inputs of timers A and B
  wire logic [1:0] aux_in    = {timer_b_aux_input, timer_a_aux_input};
  wire logic [1:0] line_in   = {port_line_three, port_line_four};
  wire logic [1:0] edge_bit  = {edge_select_register[EDGE_BIT_B],
                                edge_select_register[EDGE_BIT_A]};
  logic [1:0] aux_act;
  logic [1:0] ev_pulse;
  logic [1:0] irq_evt;
  logic [1:0] ev_lvl_q;
  logic [1:0] irq_lvl_q;

  for (genvar i = 0; i < 2; i++) begin : g_aux
    wire logic pw  = cfg[i].mode == MODE_PULSE;
    wire logic ec  = cfg[i].mode == MODE_EVENT;
    // edge bit set means active high
    wire logic act = aux_in[i] ~^ edge_bit[i];
    // port line keeps its own I/O; only its channel is borrowed
    wire logic src = (pw | ec) ? aux_in[i] : line_in[i];
    // inverted sense in pulse width flags the end of the pulse
    wire logic lvl = (src ~^ edge_bit[i]) ^ pw;

    assign aux_act[i]  = act;
    assign ev_pulse[i] = act & ~ev_lvl_q[i];
    assign irq_evt[i]  = lvl & ~irq_lvl_q[i];

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        // idle level after reset is high, so no false edge follows reset
        ev_lvl_q[i]  <= 1'b1;
        irq_lvl_q[i] <= 1'b1;
      end else begin
        ev_lvl_q[i]  <= act;
        irq_lvl_q[i] <= lvl;
      end
    end
  end

  // ========================================
  // AXI4-Lite write path
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] waddr_q;
  logic [7:0] wdata_q;
  logic       wstrb_q;

  wire logic aw_hs  = s_axi_awvalid & s_axi_awready;
  wire logic w_hs   = s_axi_wvalid & s_axi_wready;
  wire logic do_wr  = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire logic wr_map = waddr_q inside {ADDR_CTRL_AB, ADDR_CTRL_CD, ADDR_DATA_A,
                                      ADDR_DATA_B, ADDR_DATA_C, ADDR_DATA_D,
                                      ADDR_EDGE, ADDR_IRQ_EN};
  // only byte lane 0 carries register bits
  wire logic wr_en  = do_wr & wr_map & wstrb_q;

  wire logic wr_ctrl_ab = wr_en & (waddr_q == ADDR_CTRL_AB);
  wire logic wr_ctrl_cd = wr_en & (waddr_q == ADDR_CTRL_CD);
  wire logic wr_edge    = wr_en & (waddr_q == ADDR_EDGE);
  wire logic wr_irq_en  = wr_en & (waddr_q == ADDR_IRQ_EN);

  dwrite_t dwr [4];

  assign dwr[0] = '{wr: wr_en & (waddr_q == ADDR_DATA_A), val: wdata_q};
  assign dwr[1] = '{wr: wr_en & (waddr_q == ADDR_DATA_B), val: wdata_q};
  assign dwr[2] = '{wr: wr_en & (waddr_q == ADDR_DATA_C), val: wdata_q};
  assign dwr[3] = '{wr: wr_en & (waddr_q == ADDR_DATA_D), val: wdata_q};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= REG_RESET;
      wdata_q       <= REG_RESET;
      wstrb_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_have_q & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_have_q & ~s_axi_bvalid;
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb_q  <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================
  // control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ab_q            <= REG_RESET;
      ctrl_cd_q            <= REG_RESET;
      edge_select_register <= REG_RESET;
      irq_en_q             <= IRQ_EN_RESET;
    end else begin
      if (wr_ctrl_ab) ctrl_ab_q <= wdata_q;
      if (wr_ctrl_cd) ctrl_cd_q <= wdata_q & CTRL_CD_MASK;
      if (wr_edge) edge_select_register <= wdata_q;
      if (wr_irq_en) irq_en_q <= wdata_q[5:0];
    end
  end

  // ========================================
  // the four timers
  logic [7:0] cnt [4];
  logic [3:0] toggle;
  logic [3:0] tmo;

  for (genvar t = 0; t < 4; t++) begin : g_tmr
    // C and D have no auxiliary input
    wire logic act_t = (t < 2) ? aux_act[t % 2] : 1'b0;
    wire logic ev_t  = (t < 2) ? ev_pulse[t % 2] : 1'b0;

    timer_channel u_chan (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .cfg       (cfg[t]),
      .tick      (tick),
      .aux_act   (act_t),
      .ev_pulse  (ev_t),
      .dwr       (dwr[t]),
      .cnt_q     (cnt[t]),
      .toggle_q  (toggle[t]),
      .timeout_q (tmo[t])
    );
  end

  assign timer_a_toggle_out = toggle[0];
  assign timer_b_toggle_out = toggle[1];
  assign timer_c_toggle_out = toggle[2];
  assign timer_d_toggle_out = toggle[3];

  // ========================================
  // interrupt channel requests, one cycle each
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timeout_irq <= 4'h0;
      port_irq    <= 2'h0;
    end else begin
      timeout_irq <= tmo & irq_en_q[3:0];
      port_irq    <= irq_evt & irq_en_q[IRQ_EN_AUX_LSB +: 2];
    end
  end

  // ========================================
  // AXI4-Lite read path
  // reading a data address returns the live main counter
  wire logic ar_hs = s_axi_arvalid & s_axi_arready;
  wire logic [7:0] ra = s_axi_araddr;

  wire logic rd_map = ra inside {ADDR_CTRL_AB, ADDR_CTRL_CD, ADDR_DATA_A,
                                 ADDR_DATA_B, ADDR_DATA_C, ADDR_DATA_D,
                                 ADDR_EDGE, ADDR_IRQ_EN};
  wire logic [7:0] rd_val =
    (ra == ADDR_CTRL_AB) ? ctrl_ab_q :
    (ra == ADDR_CTRL_CD) ? ctrl_cd_q :
    (ra == ADDR_DATA_A)  ? cnt[0] :
    (ra == ADDR_DATA_B)  ? cnt[1] :
    (ra == ADDR_DATA_C)  ? cnt[2] :
    (ra == ADDR_DATA_D)  ? cnt[3] :
    (ra == ADDR_EDGE)    ? edge_select_register :
    (ra == ADDR_IRQ_EN)  ? {2'h0, irq_en_q} : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================
  // checks
  AST_TICK_ONE: assert property (@(posedge ref_clk) disable iff (reset)
    tick |=> !tick)
    else $error("timer tick wider than one cycle");

  AST_EC_COUNT: assert property (@(posedge ref_clk) disable iff (reset)
    cfg[0].mode == MODE_EVENT && ev_pulse[0] && cnt[0] != CNT_RELOAD_MARK
      && !dwr[0].wr |=> cnt[0] == $past(cnt[0]) - 8'h01)
    else $error("event edge did not decrement timer A");

  AST_EC_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    cfg[0].mode == MODE_EVENT && $stable(cfg[0]) && $stable(edge_bit[0])
      && ev_pulse[0] && irq_en_q[IRQ_EN_AUX_LSB] |=> port_irq[0])
    else $error("counted edge did not raise port channel");

  AST_PW_END_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    cfg[1].mode == MODE_PULSE && $stable(cfg[1]) && $stable(edge_bit[1])
      && edge_bit[1] && $fell(timer_b_aux_input) && irq_en_q[IRQ_EN_AUX_LSB + 1]
      |=> port_irq[1])
    else $error("pulse end did not interrupt");

  AST_LINE_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    cfg[1].mode == MODE_STOP && $stable(cfg[1]) && $stable(edge_bit[1]) && edge_bit[1]
      && $rose(port_line_three) && irq_en_q[IRQ_EN_AUX_LSB + 1] |=> port_irq[1])
    else $error("port line three did not raise its channel");

  AST_TMO_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
    tmo[2] && irq_en_q[2] |=> timeout_irq[2] ##1 !timeout_irq[2] || tmo[2])
    else $error("timeout not delivered to channel");

  AST_B_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule : quad_prescaled_timer_unit
`default_nettype wire

// >>> common/qtimer_pkg.sv
`default_nettype none
package qtimer_pkg;

  // ========================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL_AB = 8'h00;
  localparam logic [7:0] ADDR_CTRL_CD = 8'h04;
  localparam logic [7:0] ADDR_DATA_A  = 8'h08;
  localparam logic [7:0] ADDR_DATA_B  = 8'h0C;
  localparam logic [7:0] ADDR_DATA_C  = 8'h10;
  localparam logic [7:0] ADDR_DATA_D  = 8'h14;
  localparam logic [7:0] ADDR_EDGE    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h1C;

  // ========================================
  // field positions and reset values
  localparam int CTRL_A_LSB     = 0;
  localparam int CTRL_B_LSB     = 4;
  localparam int CTRL_C_LSB     = 4;
  localparam int CTRL_D_LSB     = 0;
  localparam int EDGE_BIT_A     = 4;
  localparam int EDGE_BIT_B     = 3;
  localparam int IRQ_EN_AUX_LSB = 4;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [5:0] IRQ_EN_RESET    = 6'h00;
  localparam logic [7:0] CTRL_CD_MASK    = 8'h77;
  localparam logic [7:0] CNT_RELOAD_MARK = 8'h01;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ========================================
  // mode codes and prescale divisors
  localparam logic [3:0] AB_MODE_STOP  = 4'h0;
  localparam logic [3:0] AB_MODE_EVENT = 4'h8;
  localparam logic [2:0] CD_MODE_STOP  = 3'h0;
  localparam logic [7:0] PRESC_4   = 8'h04;
  localparam logic [7:0] PRESC_10  = 8'h0A;
  localparam logic [7:0] PRESC_16  = 8'h10;
  localparam logic [7:0] PRESC_50  = 8'h32;
  localparam logic [7:0] PRESC_64  = 8'h40;
  localparam logic [7:0] PRESC_100 = 8'h64;
  localparam logic [7:0] PRESC_200 = 8'hC8;

  typedef enum logic [1:0] {MODE_STOP, MODE_DELAY, MODE_EVENT, MODE_PULSE} tmode_t;

  typedef struct packed {
    tmode_t     mode;
    logic [2:0] presc;
  } tcfg_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] val;
  } dwrite_t;

  function automatic logic [7:0] presc_div(input logic [2:0] sel);
    case (sel)
      3'h1: presc_div = PRESC_4;
      3'h2: presc_div = PRESC_10;
      3'h3: presc_div = PRESC_16;
      3'h4: presc_div = PRESC_50;
      3'h5: presc_div = PRESC_64;
      3'h6: presc_div = PRESC_100;
      default: presc_div = PRESC_200;
    endcase
  endfunction : presc_div

  function automatic tcfg_t decode_ab(input logic [3:0] f);
    decode_ab.presc = f[2:0];
    if (f == AB_MODE_STOP) decode_ab.mode = MODE_STOP;
    else if (f == AB_MODE_EVENT) decode_ab.mode = MODE_EVENT;
    else if (f[3]) decode_ab.mode = MODE_PULSE;
    else decode_ab.mode = MODE_DELAY;
  endfunction : decode_ab

  function automatic tcfg_t decode_cd(input logic [2:0] f);
    decode_cd.presc = f;
    decode_cd.mode  = (f == CD_MODE_STOP) ? MODE_STOP : MODE_DELAY;
  endfunction : decode_cd

endpackage : qtimer_pkg
`default_nettype wire

// >>> hw/timer_channel.sv
`default_nettype none
module timer_channel
  import qtimer_pkg::*;
(
  // clock and reset
  input  wire logic    ref_clk,
  input  wire logic    reset,
  // control
  input  wire tcfg_t   cfg,
  input  wire logic    tick,
  input  wire logic    aux_act,
  input  wire logic    ev_pulse,
  input  wire dwrite_t dwr,
  // state
  output logic [7:0]   cnt_q,
  output logic         toggle_q,
  output logic         timeout_q
);

  // ========================================
  // prescaler
  logic [7:0] presc_q;
  logic [7:0] data_q;

  wire logic       stopped   = cfg.mode == MODE_STOP;
  wire logic       ev_mode   = cfg.mode == MODE_EVENT;
  wire logic       pw_mode   = cfg.mode == MODE_PULSE;
  wire logic       presc_run = (cfg.mode == MODE_DELAY) | (pw_mode & aux_act);
  wire logic [7:0] div_last  = presc_div(cfg.presc) - 8'h01;
  // >= rather than == so a shrunk divisor still wraps at once
  wire logic       presc_hit = presc_run & tick & (presc_q >= div_last);
  wire logic       cnt_pulse = presc_hit | (ev_mode & ev_pulse);
  wire logic       at_mark   = cnt_q == CNT_RELOAD_MARK;
  wire logic       reload    = cnt_pulse & at_mark;
  wire logic       load_now  = stopped & dwr.wr;

  wire logic [7:0] presc_d = (stopped | ev_mode | presc_hit) ? '0 :
                             (presc_run & tick) ? presc_q + 8'h01 : presc_q;
  // a running write waits in data_q for the next reload
  wire logic [7:0] cnt_d = load_now ? dwr.val :
                           cnt_pulse ? (at_mark ? data_q : cnt_q - 8'h01) : cnt_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      presc_q   <= '0;
      data_q    <= REG_RESET;
      cnt_q     <= REG_RESET;
      toggle_q  <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      presc_q   <= presc_d;
      data_q    <= dwr.wr ? dwr.val : data_q;
      cnt_q     <= cnt_d;
      toggle_q  <= toggle_q ^ reload;
      timeout_q <= reload;
    end
  end

  // ========================================
  // checks
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (reset)
    reload && !load_now |=> timeout_q && cnt_q == $past(data_q))
    else $error("no reload at mark");
  AST_DECR: assert property (@(posedge ref_clk) disable iff (reset)
    cnt_pulse && !at_mark |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("count pulse did not decrement");
  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (reset)
    timeout_q |-> toggle_q != $past(toggle_q))
    else $error("output did not toggle on timeout");
  AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    stopped && !dwr.wr |=> $stable(cnt_q) && presc_q == 8'h00 && !timeout_q)
    else $error("stopped timer moved");
  AST_STOP_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
    load_now |=> cnt_q == $past(dwr.val) && data_q == $past(dwr.val))
    else $error("stopped write did not load counter");
  AST_PW_HALT: assert property (@(posedge ref_clk) disable iff (reset)
    pw_mode && !aux_act && !dwr.wr |=> $stable(cnt_q) && !timeout_q)
    else $error("pulse width timer ran while inactive");

endmodule : timer_channel
`default_nettype wire

// >>> test/aux_source_model.sv
`default_nettype none
module aux_source_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // commanded levels
  input  wire logic [1:0] want,
  // pins
  output logic            tclk,
  output logic [1:0]      aux
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_q;
  logic [4:0] hold_q;

  // ========================================
  // timer clock
  // free running at a quarter of ref_clk, well below the half-rate limit
  always_ff @(posedge ref_clk) begin
    if (reset) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign tclk = div_q[1];

  // ========================================
  // auxiliary levels
  // a change waits for four timer periods of quiet, so a fast request is delayed
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aux    <= 2'h0;
      hold_q <= 5'h00;
    end else if (want != aux && hold_q >= 5'h10) begin
      aux    <= want;
      hold_q <= 5'h00;
    end else if (hold_q != 5'h1F) begin
      hold_q <= hold_q + 5'h01;
    end
  end
endmodule : aux_source_model
`default_nettype wire

// >>> test/quad_prescaled_timer_unit_bench.sv
`default_nettype none
module quad_prescaled_timer_unit_bench import qtimer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0, reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v1, v2;
  logic [3:0]  s_axi_wstrb = 4'h0, timeout_irq;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        port_line_four = 1'b0, port_line_three = 1'b0, tclk;
  logic [3:0]  tg_q = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, port_irq, aux, want = 2'h0;
  logic        timer_a_toggle_out, timer_b_toggle_out, timer_c_toggle_out, timer_d_toggle_out;
  int          n_fail = 0, check_count = 0, c, k, p0, t0;
  int          n_tg[4] = '{0, 0, 0, 0};
  int          n_to[4] = '{0, 0, 0, 0};
  int          n_pi[2] = '{0, 0};
  logic [7:0]  divs[7] = '{PRESC_4, PRESC_10, PRESC_16, PRESC_50, PRESC_64, PRESC_100, PRESC_200};

  always #12.5 ref_clk = ~ref_clk;

  quad_prescaled_timer_unit u_quad_prescaled_timer_unit (
    .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_clock_in_one(tclk), .timer_a_aux_input(aux[0]),
    .timer_b_aux_input(aux[1]), .port_line_four, .port_line_three, .timer_a_toggle_out,
    .timer_b_toggle_out, .timer_c_toggle_out, .timer_d_toggle_out, .timeout_irq, .port_irq
  );

  aux_source_model u_aux_source_model (.ref_clk, .reset, .want, .tclk, .aux);

  // ========================================
  // pulse counters
  wire logic [3:0] tgl = {timer_d_toggle_out, timer_c_toggle_out, timer_b_toggle_out,
                          timer_a_toggle_out};
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) if (timeout_irq[i] === 1'b1) n_to[i]++;
    for (int i = 0; i < 2; i++) if (port_irq[i] === 1'b1) n_pi[i]++;
    for (int i = 0; i < 4; i++) if (tgl[i] !== tg_q[i]) n_tg[i]++;
    tg_q <= tgl;
  end

  // ========================================
  // checks and bus tasks
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic lost;
    n_fail++;
    $display("MISMATCH %0t wait ran out", $time);
    complete_run();
  endtask : lost

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) lost();
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) lost();
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er, "read response");
    @(posedge ref_clk);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    rd(a, d, er);
    chk(d, exp, "read data");
  endtask : rdc

  task automatic wait_to(input int t);
    for (c = 1; c < 5000; c++) begin
      @(posedge ref_clk);
      if (timeout_irq[t] === 1'b1) return;
    end
    lost();
  endtask : wait_to

  // the third gap is measured, so a skew after a prescale change is tolerated
  task automatic per(input int t, input int exp);
    repeat (3) wait_to(t);
    chk(c, exp, "timeout period");
  endtask : per

  task automatic aux_pulse(input int b);
    want[b] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    want[b] <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask : aux_pulse

  // ========================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc(ADDR_CTRL_AB, 32'h0, RESP_OKAY);
    rdc(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 8'h01, RESP_SLVERR);
    wr(ADDR_IRQ_EN, 8'h3F, RESP_OKAY);
    wr(ADDR_EDGE, 8'h18, RESP_OKAY);
    port_line_four <= 1'b1;
    port_line_three <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(n_pi[0], 1, "port line channel");
    chk(n_pi[1], 1, "port line three channel");
    wr(ADDR_DATA_A, 8'h02, RESP_OKAY);
    rdc(ADDR_DATA_A, 32'h2, RESP_OKAY);
    wr(ADDR_CTRL_AB, 8'h01, RESP_OKAY);
    per(0, 2 * 4 * 4);
    @(posedge ref_clk);
    chk(n_tg[0], n_to[0], "toggle per timeout");
    wr(ADDR_DATA_A, 8'h03, RESP_OKAY);
    per(0, 3 * 4 * 4);
    wr(ADDR_CTRL_AB, 8'h00, RESP_OKAY);
    t0 = n_to[0];
    rd(ADDR_DATA_A, v1, RESP_OKAY);
    repeat (100) @(posedge ref_clk);
    rd(ADDR_DATA_A, v2, RESP_OKAY);
    chk(v2, v1, "stopped counter");
    chk(n_to[0], t0, "stopped timeouts");
    wr(ADDR_DATA_C, 8'h01, RESP_OKAY);
    for (k = 1; k < 8; k++) begin
      wr(ADDR_CTRL_CD, 8'(k << 4), RESP_OKAY);
      per(2, int'(divs[k - 1]) * 4);
    end
    wr(ADDR_DATA_D, 8'h00, RESP_OKAY);
    wr(ADDR_CTRL_CD, 8'h01, RESP_OKAY);
    per(3, 256 * 16);
    @(posedge ref_clk);
    chk(n_tg[2], n_to[2], "timer C toggles");
    chk(n_tg[3], n_to[3], "timer D toggles");
    wr(ADDR_CTRL_CD, 8'h00, RESP_OKAY);
    // event count on A, rising edges
    wr(ADDR_DATA_A, 8'h03, RESP_OKAY);
    wr(ADDR_CTRL_AB, AB_MODE_EVENT, RESP_OKAY);
    p0 = n_pi[0];
    t0 = n_to[0];
    port_line_four <= 1'b0;
    repeat (4) @(posedge ref_clk);
    port_line_four <= 1'b1;
    repeat (3) aux_pulse(0);
    chk(n_pi[0] - p0, 3, "event interrupts");
    chk(n_to[0] - t0, 1, "event timeouts");
    rdc(ADDR_DATA_A, 32'h3, RESP_OKAY);
    // falling edges; the edge bit change itself counts once
    t0 = n_to[0];
    wr(ADDR_EDGE, 8'h08, RESP_OKAY);
    repeat (2) aux_pulse(0);
    chk(n_to[0] - t0, 1, "falling edge timeouts");
    rdc(ADDR_DATA_A, 32'h3, RESP_OKAY);
    // pulse width on B, active high
    wr(ADDR_DATA_B, 8'hFF, RESP_OKAY);
    wr(ADDR_CTRL_AB, 8'h90, RESP_OKAY);
    repeat (10) @(posedge ref_clk);
    rdc(ADDR_DATA_B, 32'hFF, RESP_OKAY);
    p0 = n_pi[1];
    want[1] <= 1'b1;  // data written well before the pulse turns active
    repeat (200) @(posedge ref_clk);
    chk(n_pi[1] - p0, 0, "no interrupt at pulse start");
    want[1] <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(n_pi[1] - p0, 1, "interrupt at pulse end");
    rd(ADDR_DATA_B, v1, RESP_OKAY);
    chk(32'(v1 > 32'hF0 && v1 < 32'hFF), 32'h1, "measured width");
    repeat (100) @(posedge ref_clk);
    rdc(ADDR_DATA_B, v1, RESP_OKAY);
    // rewrite after reading; the running counter keeps its value until 01
    wr(ADDR_DATA_B, 8'h02, RESP_OKAY);
    rdc(ADDR_DATA_B, v1, RESP_OKAY);
    want[1] <= 1'b1;
    wait_to(1);
    want[1] <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(n_tg[1], n_to[1], "timer B toggles");
    complete_run();
  end
endmodule : quad_prescaled_timer_unit_bench
`default_nettype wire
